// [rtl/dsr_buffer.sv]
// Two-entry valid/ready buffer for converter result pairs.
// Assumes both sides sit on the system clock.
module dsr_buffer (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        in_valid,
  output logic             in_ready,
  input  wire logic [23:0] in_data,
  output logic             out_valid,
  input  wire logic        out_ready,
  output logic [23:0]      out_data
);

  logic [23:0] mem_reg [dsr_pkg::BUF_DEPTH];
  logic        wr_ptr_reg;
  logic        rd_ptr_reg;
  logic [1:0]  count_reg;
  logic        push;
  logic        pop;

  // ----------------------------------------------------------------
  // Handshake
  // ----------------------------------------------------------------
  assign in_ready  = (count_reg != 2'h2);
  assign out_valid = (count_reg != 2'h0);
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem_reg[rd_ptr_reg];

  // Storage write
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mem_reg[0] <= 24'h000000;
      mem_reg[1] <= 24'h000000;
    end else if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg  <= 2'h0;
    end else begin
      if (push)
        wr_ptr_reg <= ~wr_ptr_reg;
      if (pop)
        rd_ptr_reg <= ~rd_ptr_reg;
      if (push && !pop)
        count_reg <= count_reg + 2'h1;
      else if (pop && !push)
        count_reg <= count_reg - 2'h1;
    end
  end

endmodule

// [rtl/dsr_pkg.sv]
// Constants for the dual converter serial readout block.
// Assumes a 25 MHz system clock and an externally driven serial clock.
package dsr_pkg;

  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam int unsigned RESULT_BITS    = 12;
  localparam int unsigned SHORT_FRAME    = 14;
  localparam int unsigned LONG_FRAME     = 16;
  localparam int unsigned FRAME_CNT_W    = 6;
  localparam logic [5:0]  SECOND_START   = 6'h10;
  localparam logic [5:0]  SECOND_END     = 6'h20;
  localparam logic [5:0]  ID_SLOT        = 6'h01;
  localparam logic [5:0]  DATA_FIRST     = 6'h02;
  localparam logic [5:0]  DATA_LAST      = 6'h0d;

  // ----------------------------------------------------------------
  // Identification bit values
  // ----------------------------------------------------------------
  localparam logic        ID_FIRST_CONV  = 1'b0;
  localparam logic        ID_SECOND_CONV = 1'b1;

  // ----------------------------------------------------------------
  // Channel decode and reset values
  // ----------------------------------------------------------------
  localparam int unsigned CHAN_SEL_W     = 3;
  localparam logic [2:0]  SGL_MAX_CHAN   = 3'h5;
  localparam logic [2:0]  DIFF_MAX_CHAN  = 3'h2;
  localparam logic [11:0] RESULT_RESET   = 12'h000;
  localparam logic [2:0]  CHAN_RESET     = 3'h0;

  // Result buffer depth
  localparam int unsigned BUF_DEPTH      = 2;

  typedef enum logic [1:0] {
    DSR_IDLE,
    DSR_FRAME
  } dsr_state_type;

endpackage

// [rtl/dsr_readout.sv]
// Digital control and serial readout of a dual 12-bit converter.
// Assumes chip select and serial clock come from a host, asynchronous
// to clk; results arrive from the converter cores on a valid/ready port.
//
// Summary of operation
// RULE1 - Chip select fall starts conversion, frames transfer
// RULE2 - Outputs change on serial clock falling edge
// RULE3 - Both outputs drive their frames together
// RULE4 - Frame: zero, identification bit, twelve result bits
// RULE5 - Result shifted most significant bit first
// RULE6 - Sixteen clocks give two trailing zeros
// RULE7 - Further sixteen clocks deliver other converter result
// RULE8 - Range select sampled at chip select fall
// RULE9 - Channel select latched at chip select fall
// RULE10 - Config select picks differential or single-ended
// RULE11 - Reference select low means internal reference
// RULE12 - Serial clock paces conversion progress
// RULE13 - Identification bit names the source converter
// RULE14 - Channel select decoded to per-converter index
module dsr_readout (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        chip_select_n,
  input  wire logic        serial_clk,
  input  wire logic        range_select,
  input  wire logic [2:0]  channel_pair_select,
  input  wire logic        input_config_select,
  input  wire logic        ref_select,
  input  wire logic        result_valid,
  output logic             result_ready,
  input  wire logic [11:0] result_first,
  input  wire logic [11:0] result_second,
  output logic             serial_out_first,
  output logic             serial_out_second,
  output logic             conv_start,
  output logic             conv_step,
  output logic             range_double,
  output logic             single_ended,
  output logic             use_internal_ref,
  output logic [2:0]       channel_index,
  output logic             channel_valid,
  output logic             sample_missing
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [1:0] csn_sync_reg;
  logic [1:0] sclk_sync_reg;
  logic       csn_prev_reg;
  logic       sclk_prev_reg;
  logic [1:0] rng_sync_reg;
  logic [1:0] cfg_sync_reg;
  logic [1:0] ref_sync_reg;
  logic [2:0] chan_meta_reg;
  logic [2:0] chan_sync_reg;

  // Two flops on every pin input
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      csn_sync_reg  <= 2'h3;
      sclk_sync_reg <= 2'h3;
      rng_sync_reg  <= 2'h0;
      cfg_sync_reg  <= 2'h0;
      ref_sync_reg  <= 2'h0;
      chan_meta_reg <= dsr_pkg::CHAN_RESET;
      chan_sync_reg <= dsr_pkg::CHAN_RESET;
    end else begin
      csn_sync_reg  <= {csn_sync_reg[0], chip_select_n};
      sclk_sync_reg <= {sclk_sync_reg[0], serial_clk};
      rng_sync_reg  <= {rng_sync_reg[0], range_select};
      cfg_sync_reg  <= {cfg_sync_reg[0], input_config_select};
      ref_sync_reg  <= {ref_sync_reg[0], ref_select};
      chan_meta_reg <= channel_pair_select;
      chan_sync_reg <= chan_meta_reg;
    end
  end

  // Edge history of synchronised levels
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      csn_prev_reg  <= 1'b1;
      sclk_prev_reg <= 1'b1;
    end else begin
      csn_prev_reg  <= csn_sync_reg[1];
      sclk_prev_reg <= sclk_sync_reg[1];
    end
  end

  logic cs_fall;
  logic sclk_fall;
  logic frame_on;

  assign cs_fall   = csn_prev_reg & ~csn_sync_reg[1];           // see RULE1
  assign sclk_fall = sclk_prev_reg & ~sclk_sync_reg[1];
  assign frame_on  = ~csn_sync_reg[1];

  // ----------------------------------------------------------------
  // Configuration captured at frame start; reference select is followed continuously
  // ----------------------------------------------------------------
  logic       range_reg;
  logic [2:0] chan_reg;
  logic       sgl_reg;

  // Latch settings on chip select fall
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      range_reg <= 1'b0;
      chan_reg  <= dsr_pkg::CHAN_RESET;
      sgl_reg   <= 1'b0;
    end else if (cs_fall) begin
      range_reg <= rng_sync_reg[1];                             // see RULE8
      chan_reg  <= chan_sync_reg;                               // see RULE9
      sgl_reg   <= cfg_sync_reg[1];                             // see RULE10
    end
  end

  // Per-converter channel decode
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      channel_index <= dsr_pkg::CHAN_RESET;
      channel_valid <= 1'b0;
    end else begin
      channel_index <= chan_reg;                                // see RULE14
      channel_valid <= sgl_reg ? (chan_reg <= dsr_pkg::SGL_MAX_CHAN)
                               : (chan_reg <= dsr_pkg::DIFF_MAX_CHAN);
    end
  end

  // Static settings to the analog side
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      range_double     <= 1'b0;
      single_ended     <= 1'b0;
      use_internal_ref <= 1'b1;
    end else begin
      range_double     <= range_reg;                            // see RULE8
      single_ended     <= sgl_reg;                              // see RULE10
      use_internal_ref <= ~ref_sync_reg[1];                     // see RULE11
    end
  end

  // ----------------------------------------------------------------
  // Conversion pacing
  // ----------------------------------------------------------------
  // Start pulse on frame start, one step per serial clock fall while chip select is low
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      conv_start <= 1'b0;
      conv_step  <= 1'b0;
    end else begin
      conv_start <= cs_fall;                                    // see RULE1
      conv_step  <= frame_on & sclk_fall;                       // see RULE12
    end
  end

  // ----------------------------------------------------------------
  // Result buffer
  // ----------------------------------------------------------------
  logic        buf_valid;
  logic        buf_ready;
  logic [23:0] buf_data;

  dsr_buffer u_buffer (
    .clk       (clk),
    .resetn    (resetn),
    .in_valid  (result_valid),
    .in_ready  (result_ready),
    .in_data   ({result_first, result_second}),
    .out_valid (buf_valid),
    .out_ready (buf_ready),
    .out_data  (buf_data)
  );

  // Take one result pair per frame at chip select fall
  assign buf_ready = cs_fall;

  // ----------------------------------------------------------------
  // Frame shifter
  // ----------------------------------------------------------------
  dsr_pkg::dsr_state_type state_reg;
  logic [5:0]  bit_cnt_reg;
  logic [11:0] word_first_reg;
  logic [11:0] word_second_reg;

  // Frame state and bit counter
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg   <= dsr_pkg::DSR_IDLE;
      bit_cnt_reg <= 6'h00;
    end else begin
      case (state_reg)
        dsr_pkg::DSR_IDLE: begin
          bit_cnt_reg <= 6'h00;
          if (cs_fall)
            state_reg <= dsr_pkg::DSR_FRAME;                    // see RULE1
        end
        dsr_pkg::DSR_FRAME: begin
          if (!frame_on) begin
            state_reg <= dsr_pkg::DSR_IDLE;
          end else if (sclk_fall && bit_cnt_reg != dsr_pkg::SECOND_END) begin
            bit_cnt_reg <= bit_cnt_reg + 6'h01;
          end
        end
        default: state_reg <= dsr_pkg::DSR_IDLE;
      endcase
    end
  end

  // Capture result pair for this frame
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      word_first_reg  <= dsr_pkg::RESULT_RESET;
      word_second_reg <= dsr_pkg::RESULT_RESET;
      sample_missing  <= 1'b0;
    end else if (cs_fall) begin
      word_first_reg  <= buf_valid ? buf_data[23:12] : dsr_pkg::RESULT_RESET;
      word_second_reg <= buf_valid ? buf_data[11:0] : dsr_pkg::RESULT_RESET;
      sample_missing  <= ~buf_valid;
    end
  end

  // Bit for a given slot of a 16-clock half frame
  function automatic logic slot_bit(input logic [5:0] slot,
                                    input logic       id,
                                    input logic [11:0] word);
    logic [3:0] idx;
    idx = 4'h0;
    if (slot == 6'h00) begin
      slot_bit = 1'b0;                                          // see RULE4
    end else if (slot == dsr_pkg::ID_SLOT) begin
      slot_bit = id;                                            // see RULE13
    end else if (slot <= dsr_pkg::DATA_LAST) begin
      idx      = 4'(dsr_pkg::DATA_LAST - slot);
      slot_bit = word[idx];                                     // see RULE5
    end else begin
      slot_bit = 1'b0;                                          // see RULE6
    end
  endfunction

  logic       second_half;
  logic [5:0] slot;
  logic [5:0] bit_cnt_next;
  logic       next_a;
  logic       next_b;

  // Slot that the coming serial clock fall presents
  assign bit_cnt_next = bit_cnt_reg + 6'h01;
  assign second_half  = (bit_cnt_next >= dsr_pkg::SECOND_START);
  assign slot         = second_half ? bit_cnt_next - dsr_pkg::SECOND_START
                                    : bit_cnt_next;

  // Second half swaps converters on each output
  always_comb begin
    if (bit_cnt_next >= dsr_pkg::SECOND_END) begin
      next_a = 1'b0;
      next_b = 1'b0;
    end else if (second_half) begin                             // see RULE7
      next_a = slot_bit(slot, dsr_pkg::ID_SECOND_CONV, word_second_reg);
      next_b = slot_bit(slot, dsr_pkg::ID_FIRST_CONV, word_first_reg);
    end else begin                                              // see RULE3
      next_a = slot_bit(slot, dsr_pkg::ID_FIRST_CONV, word_first_reg);
      next_b = slot_bit(slot, dsr_pkg::ID_SECOND_CONV, word_second_reg);
    end
  end

  // Output bits update on serial clock fall
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      serial_out_first  <= 1'b0;
      serial_out_second <= 1'b0;
    end else if (cs_fall || !frame_on) begin
      serial_out_first  <= 1'b0;                                // see RULE4
      serial_out_second <= 1'b0;
    end else if (state_reg == dsr_pkg::DSR_FRAME && sclk_fall) begin
      serial_out_first  <= next_a;                              // see RULE2
      serial_out_second <= next_b;                              // see RULE3
    end
  end

endmodule

// [sim/dsr_host.sv]
// Host serial port model: frames reads and shifts in both outputs.
// Assumes the bench clk; serial clock idles high between frames.
module dsr_host (
  input  wire logic clk,
  output logic      chip_select_n,
  output logic      serial_clk,
  input  wire logic serial_out_first,
  input  wire logic serial_out_second
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] got_first;
  logic [31:0] got_second;

  // Idle levels
  initial begin
    chip_select_n = 1'b1;
    serial_clk = 1'b1;
  end

  // One read of n serial clocks of 320 ns, newest bit at the bottom
  task automatic frame(input int n);
    got_first = 32'h0;
    got_second = 32'h0;
    @(negedge clk);
    chip_select_n = 1'b0;
    repeat (8) @(negedge clk);
    for (int k = 0; k < n; k++) begin
      got_first = {got_first[30:0], serial_out_first};
      got_second = {got_second[30:0], serial_out_second};
      serial_clk = 1'b0;
      repeat (4) @(negedge clk);
      serial_clk = 1'b1;
      repeat (4) @(negedge clk);
    end
    chip_select_n = 1'b1;
    repeat (8) @(negedge clk);
  endtask
endmodule

// [sim/dsr_readout_asserts.sv]
// Port assertions for the dual converter serial readout block.
// Assumes one clk domain with async resetn; bound from the bench.
module dsr_readout_asserts (
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic       chip_select_n,
  input wire logic       serial_clk,
  input wire logic       range_select,
  input wire logic [2:0] channel_pair_select,
  input wire logic       input_config_select,
  input wire logic       ref_select,
  input wire logic       serial_out_first,
  input wire logic       serial_out_second,
  input wire logic       conv_start,
  input wire logic       conv_step,
  input wire logic       range_double,
  input wire logic       single_ended,
  input wire logic       use_internal_ref,
  input wire logic [2:0] channel_index,
  input wire logic       channel_valid,
  input wire logic       sample_missing
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!resetn);
  logic [2:0] hi_cnt_reg;

  // Cycles the serial clock has stayed high
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) hi_cnt_reg <= 3'h0;
    else if (!serial_clk) hi_cnt_reg <= 3'h0;
    else if (hi_cnt_reg != 3'h7) hi_cnt_reg <= hi_cnt_reg + 3'h1;
  end

  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  start_on_fall_a: assert property (
    $fell(chip_select_n) |-> ##[1:6] conv_start)
    else $error("no conversion start after frame open");
  start_single_a: assert property (
    conv_start |=> !conv_start)
    else $error("conversion start longer than one cycle");
  step_on_fall_a: assert property (
    $fell(serial_clk) && !chip_select_n |-> ##[2:5] conv_step)
    else $error("serial clock fall gave no step");
  step_in_frame_a: assert property (
    conv_step |-> !chip_select_n)
    else $error("step outside a frame");
  out_hold_a: assert property (
    hi_cnt_reg >= 3'h2 && !chip_select_n |->
      $stable({serial_out_first, serial_out_second}))
    else $error("output moved while serial clock high");
  idle_zero_a: assert property (
    chip_select_n [*4] |-> !serial_out_first && !serial_out_second)
    else $error("output not zero outside frame");
  lead_zero_a: assert property (
    conv_start |-> !serial_out_first && !serial_out_second)
    else $error("leading zero missing");
  frame_settings_a: assert property (
    conv_start |-> ##2 range_double == range_select &&
      single_ended == input_config_select &&
      use_internal_ref == !ref_select)
    else $error("frame settings not applied");
  chan_latch_a: assert property (
    conv_start |-> ##2 channel_index == channel_pair_select)
    else $error("channel not latched");
  chan_legal_a: assert property (
    conv_start |-> ##2 channel_valid == (input_config_select ?
      channel_pair_select <= dsr_pkg::SGL_MAX_CHAN :
      channel_pair_select <= dsr_pkg::DIFF_MAX_CHAN))
    else $error("channel legality wrong");
  cover property (conv_start);
  cover property (conv_step && sample_missing);
  cover property (conv_start ##2 !channel_valid);
endmodule

// [sim/tb_dsr_readout.sv]
// Self-checking bench for the dual converter serial readout block.
// Assumes the host model drives the link; inputs move at clk fall.
module tb_dsr_readout;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk;
  logic        resetn;
  logic        chip_select_n;
  logic        serial_clk;
  logic        range_select;
  logic [2:0]  channel_pair_select;
  logic        input_config_select;
  logic        ref_select;
  logic        result_valid;
  logic        result_ready;
  logic [11:0] result_first;
  logic [11:0] result_second;
  logic        serial_out_first;
  logic        serial_out_second;
  logic        conv_start;
  logic        conv_step;
  logic        range_double;
  logic        single_ended;
  logic        use_internal_ref;
  logic [2:0]  channel_index;
  logic        channel_valid;
  logic        sample_missing;
  int          err_total = 0;
  int          compares = 0;
  int          cycles = 0;

  dsr_readout i_dsr_readout (
    .clk                 (clk),
    .resetn              (resetn),
    .chip_select_n       (chip_select_n),
    .serial_clk          (serial_clk),
    .range_select        (range_select),
    .channel_pair_select (channel_pair_select),
    .input_config_select (input_config_select),
    .ref_select          (ref_select),
    .result_valid        (result_valid),
    .result_ready        (result_ready),
    .result_first        (result_first),
    .result_second       (result_second),
    .serial_out_first    (serial_out_first),
    .serial_out_second   (serial_out_second),
    .conv_start          (conv_start),
    .conv_step           (conv_step),
    .range_double        (range_double),
    .single_ended        (single_ended),
    .use_internal_ref    (use_internal_ref),
    .channel_index       (channel_index),
    .channel_valid       (channel_valid),
    .sample_missing      (sample_missing)
  );
  dsr_host i_dsr_host (.clk, .chip_select_n, .serial_clk,
    .serial_out_first, .serial_out_second);

  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      close_out();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Offer one result pair and hold it until taken
  task automatic push(input logic [11:0] a, input logic [11:0] b);
    result_first = a;
    result_second = b;
    result_valid = 1'b1;
    while (result_ready !== 1'b1) @(negedge clk);
    @(negedge clk);
    result_valid = 1'b0;
    @(negedge clk);
  endtask

  task automatic setup(input logic r, input logic [2:0] c,
                       input logic s, input logic f);
    range_select = r;
    channel_pair_select = c;
    input_config_select = s;
    ref_select = f;
  endtask

  // Short frame, single-ended, internal reference
  task automatic t_short();
    setup(1'b1, 3'h5, 1'b1, 1'b0);
    push(12'ha5c, 12'h3e1);
    i_dsr_host.frame(14);
    check(i_dsr_host.got_first, {18'h0, 2'b00, 12'ha5c});
    check(i_dsr_host.got_second, {18'h0, 2'b01, 12'h3e1});
    check(32'({range_double, single_ended, use_internal_ref, channel_index,
      channel_valid, sample_missing}), 32'hf6);
    $display("test short done");
  endtask

  // Full buffer, then both words on each output, then a 16-clock read
  task automatic t_full();
    setup(1'b0, 3'h3, 1'b0, 1'b1);
    push(12'h801, 12'h17e);
    push(12'hc33, 12'h0f5);
    check(32'(result_ready), 32'h0);
    i_dsr_host.frame(32);
    check(i_dsr_host.got_first, {16'h2004, 16'h45f8});
    check(i_dsr_host.got_second, {16'h45f8, 16'h2004});
    check(32'({range_double, single_ended, use_internal_ref, channel_index,
      channel_valid, result_ready}), 32'h0d);
    i_dsr_host.frame(16);
    check(i_dsr_host.got_first, {16'h0, 16'h30cc});
    check(i_dsr_host.got_second, {16'h0, 16'h43d4});
    $display("test full done");
  endtask

  // Read with nothing buffered
  task automatic t_empty();
    i_dsr_host.frame(14);
    check(32'(sample_missing), 32'h1);
    check(i_dsr_host.got_first, 32'h0);
    check(i_dsr_host.got_second, 32'h1000);
    $display("test empty done");
  endtask

  // Main sequence
  initial begin
    resetn = 1'b0;
    result_valid = 1'b0;
    result_first = 12'h000;
    result_second = 12'h000;
    setup(1'b0, 3'h0, 1'b0, 1'b0);
    repeat (11) @(negedge clk);
    check(32'({result_ready, use_internal_ref, channel_index,
      serial_out_first, serial_out_second, conv_start}), 32'hc0);
    @(negedge clk);
    resetn = 1'b1;
    repeat (2) @(negedge clk);
    $display("test reset done");
    t_short();
    t_full();
    t_empty();
    close_out();
  end
endmodule

bind dsr_readout dsr_readout_asserts i_dsr_readout_asserts (.clk, .resetn,
  .chip_select_n, .serial_clk, .range_select, .channel_pair_select,
  .input_config_select, .ref_select, .serial_out_first, .serial_out_second,
  .conv_start, .conv_step, .range_double, .single_ended, .use_internal_ref,
  .channel_index, .channel_valid, .sample_missing);
